// *** hdl/save_restore_defines.svh ***
// Offsets, key words, subindex numbers and category masks of the save/restore block.
`ifndef SAVE_RESTORE_DEFINES_SVH
`define SAVE_RESTORE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------------------
`define IDX_STORE_COMMAND 16'h1010
`define IDX_DISCARD_COMMAND 16'h1011
`define IDX_CONFIG_VERIFY_MARKER 16'h1020
`define IDX_USER_MEMORY_AREA 16'h2700

// ----------------------------------------------------------------------------
// Key words and status values
// ----------------------------------------------------------------------------
`define KEY_SAVE 32'h65766173
`define KEY_DISCARD 32'h64616F6C
`define WORD_ZERO 32'h00000000
`define WORD_ONE 32'h00000001

// ----------------------------------------------------------------------------
// Subindices
// ----------------------------------------------------------------------------
`define SUB_ZERO 8'h00
`define SUB_ALL 8'h01
`define SUB_COMM 8'h02
`define SUB_APPL 8'h03
`define SUB_CUST 8'h04
`define SUB_DRIVE 8'h05
`define SUB_TUNING 8'h06
`define SUB_MARK_DATE 8'h01
`define SUB_MARK_TIME 8'h02
`define SUB_USER_START 8'h01
`define SUB_USER_FIRST 8'h02
`define SUB_USER_LAST 8'h09
`define CMD_HIGHEST_SUB 32'h00000006
`define MARK_HIGHEST_SUB 32'h00000002
`define USER_HIGHEST_SUB 32'h00000009

// ----------------------------------------------------------------------------
// Category mask towards the store: comm, appl, cust, drive, tuning, marker
// ----------------------------------------------------------------------------
`define CAT_W 6
`define CAT_NONE 6'h00
`define CAT_COMM 6'h01
`define CAT_APPL 6'h02
`define CAT_CUST 6'h04
`define CAT_DRIVE 6'h08
`define CAT_TUNING 6'h10
`define CAT_MARKER 6'h20
`define CAT_TUNING_BIT 4
`define CAT_SAVE_ALL 6'h3F
`define CAT_DISCARD_ALL 6'h2F
`define CAT_USER 6'h04

`endif

// *** hdl/save_restore_pkg.sv ***
// Types shared by the save/restore block.
package save_restore_pkg;

  typedef enum logic [1:0] {
    NV_LOAD,
    NV_SAVE,
    NV_ERASE,
    NV_USER
  } nv_op_type;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_LOAD,
    ST_IDLE,
    ST_SAVE,
    ST_ERASE,
    ST_USER,
    ST_RESTART
  } sr_state_type;

endpackage

// *** hdl/user_value_mem.sv ***
// Small memory holding the user values, read data from a register.
`timescale 1ns/1ps
`default_nettype none

module user_value_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output var logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents carry no reset; only dictionary writes to subindices 02..09 fill them.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// *** hdl/parameter_save_restore.sv ***
// Save, discard and reload control for dictionary categories kept in the nonvolatile store.
//
// Functional notes
// - Save key into store subindex saves category.
// - Finished save turns subindex value into one.
// - Subindices 01..06 select all, comm, appl, cust, drive, tuning.
// - Discard key deletes saved values of category.
// - Discard-all restores factory, keeps saved tuning.
// - After deletion the device restarts by itself.
// - Tuning erased only through discard subindex 06.
// - Savable writes clear marker; save-all, marker exempt.
// - Marker date and time saved with save-all.
// - User memory holds eight 16-bit values, 02..09.
// - One into user subindex 01 saves; zero when done.
// - Only whole categories saved, never live values.
// - Saved values reload after power-on or reset.
`timescale 1ns/1ps
`default_nettype none
`include "save_restore_defines.svh"

module parameter_save_restore #(
  parameter int USER_WIDTH = 16,
  parameter int USER_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic od_savable,
  output var logic od_ack,
  output var logic od_err,
  output var logic [31:0] od_rdata,
  output var logic nv_req,
  output var save_restore_pkg::nv_op_type nv_op,
  output var logic [`CAT_W-1:0] nv_mask,
  input wire logic nv_done,
  output var logic restart,
  output var logic busy
);
  import save_restore_pkg::*;

  // --------------------------------------------------------------------------
  // Request stage
  // --------------------------------------------------------------------------
  logic req_vld_q, req_vld_d, req_wr_q, req_wr_d, req_sav_q, req_sav_d;
  logic [15:0] req_idx_q, req_idx_d;
  logic [7:0] req_sub_q, req_sub_d;
  logic [31:0] req_data_q, req_data_d;
  logic [USER_WIDTH-1:0] mem_rdata;
  logic mem_wr;

  // One access at a time; a request during the pending one is dropped.
  always_comb begin
    req_vld_d = (od_wr | od_rd) & ~req_vld_q & ~od_ack;
    req_wr_d = od_wr;
    req_sav_d = od_savable;
    req_idx_d = od_index;
    req_sub_d = od_sub;
    req_data_d = od_wdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_vld_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_sav_q <= 1'b0;
      req_idx_q <= 16'h0000;
      req_sub_q <= 8'h00;
      req_data_q <= 32'h00000000;
    end else begin
      req_vld_q <= req_vld_d;
      req_wr_q <= req_wr_d;
      req_sav_q <= req_sav_d;
      req_idx_q <= req_idx_d;
      req_sub_q <= req_sub_d;
      req_data_q <= req_data_d;
    end
  end

  // --------------------------------------------------------------------------
  // Decode of the pending request
  // --------------------------------------------------------------------------
  logic wr_now, cmd_sub_ok, is_store, is_disc, is_mark, is_user, user_slot;
  logic store_ok, disc_ok, user_go, mark_clr, idle;
  logic [`CAT_W-1:0] save_mask, disc_mask;
  sr_state_type st_q, st_d;
  logic nv_req_q, nv_req_d, restart_q, restart_d, user_flag_q, user_flag_d;
  nv_op_type nv_op_q, nv_op_d;
  logic [`CAT_W-1:0] nv_mask_q, nv_mask_d;
  logic [7:0] cmd_sub_q, cmd_sub_d;

  assign idle = (st_q == ST_IDLE);
  assign wr_now = req_vld_q & req_wr_q;
  assign cmd_sub_ok = (req_sub_q >= `SUB_ALL) && (req_sub_q <= `SUB_TUNING);
  assign is_store = (req_idx_q == `IDX_STORE_COMMAND);
  assign is_disc = (req_idx_q == `IDX_DISCARD_COMMAND);
  assign is_mark = (req_idx_q == `IDX_CONFIG_VERIFY_MARKER);
  assign is_user = (req_idx_q == `IDX_USER_MEMORY_AREA);
  assign user_slot = (req_sub_q >= `SUB_USER_FIRST) && (req_sub_q <= `SUB_USER_LAST);
  // Only the exact key starts a save or discard, and only one starts a user save; any other value is refused.
  assign store_ok = wr_now & is_store & cmd_sub_ok & idle & (req_data_q == `KEY_SAVE);
  assign disc_ok = wr_now & is_disc & cmd_sub_ok & idle & (req_data_q == `KEY_DISCARD);
  assign user_go = wr_now & is_user & (req_sub_q == `SUB_USER_START) & idle
                 & (req_data_q == `WORD_ONE);
  assign mem_wr = wr_now & is_user & user_slot;
  // Savable writes and store-command subindices other than save-all wipe the marker.
  assign mark_clr = wr_now & ~is_mark
                  & (req_sav_q | (is_store & (req_sub_q != `SUB_ALL)));

  // Whole categories only; the marker travels with save-all and discard-all alone.
  always_comb begin
    unique case (req_sub_q)
      `SUB_ALL: save_mask = `CAT_SAVE_ALL;
      `SUB_COMM: save_mask = `CAT_COMM;
      `SUB_APPL: save_mask = `CAT_APPL;
      `SUB_CUST: save_mask = `CAT_CUST;
      `SUB_DRIVE: save_mask = `CAT_DRIVE;
      `SUB_TUNING: save_mask = `CAT_TUNING;
      default: save_mask = `CAT_NONE;
    endcase
    disc_mask = (req_sub_q == `SUB_ALL) ? `CAT_DISCARD_ALL : save_mask;
  end

  // --------------------------------------------------------------------------
  // Sequencer towards the nonvolatile store
  // --------------------------------------------------------------------------
  // A save may last seconds, so the sequencer simply waits for the store.
  always_comb begin
    st_d = st_q;
    nv_req_d = 1'b0;
    nv_op_d = nv_op_q;
    nv_mask_d = nv_mask_q;
    restart_d = 1'b0;
    cmd_sub_d = cmd_sub_q;
    user_flag_d = user_flag_q;
    unique case (st_q)
      ST_BOOT: begin
        nv_req_d = 1'b1;
        nv_op_d = NV_LOAD;
        nv_mask_d = `CAT_SAVE_ALL;
        st_d = ST_LOAD;
      end
      ST_LOAD: if (nv_done) st_d = ST_IDLE;
      ST_IDLE: begin
        if (store_ok) begin
          nv_req_d = 1'b1;
          nv_op_d = NV_SAVE;
          nv_mask_d = save_mask;
          cmd_sub_d = req_sub_q;
          st_d = ST_SAVE;
        end else if (disc_ok) begin
          nv_req_d = 1'b1;
          nv_op_d = NV_ERASE;
          nv_mask_d = disc_mask;
          cmd_sub_d = req_sub_q;
          st_d = ST_ERASE;
        end else if (user_go) begin
          nv_req_d = 1'b1;
          nv_op_d = NV_USER;
          nv_mask_d = `CAT_USER;
          user_flag_d = 1'b1;
          st_d = ST_USER;
        end
      end
      ST_SAVE: if (nv_done) st_d = ST_IDLE;
      ST_ERASE: begin
        if (nv_done) begin
          restart_d = 1'b1;
          st_d = ST_RESTART;
        end
      end
      ST_USER: begin
        if (nv_done) begin
          user_flag_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      ST_RESTART: st_d = ST_BOOT;
      default: st_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_BOOT;
      nv_req_q <= 1'b0;
      nv_op_q <= NV_LOAD;
      nv_mask_q <= `CAT_NONE;
      restart_q <= 1'b0;
      cmd_sub_q <= `SUB_ZERO;
      user_flag_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nv_req_q <= nv_req_d;
      nv_op_q <= nv_op_d;
      nv_mask_q <= nv_mask_d;
      restart_q <= restart_d;
      cmd_sub_q <= cmd_sub_d;
      user_flag_q <= user_flag_d;
    end
  end

  // --------------------------------------------------------------------------
  // Marker entries and access answer
  // --------------------------------------------------------------------------
  logic [31:0] mark_date_q, mark_date_d, mark_time_q, mark_time_d, rdata_q, rdata_d;
  logic ack_q, ack_d, err_q, err_d;

  // The answer is registered, so it follows the request by two cycles.
  always_comb begin
    mark_date_d = mark_date_q;
    mark_time_d = mark_time_q;
    if (mark_clr) begin
      mark_date_d = `WORD_ZERO;
      mark_time_d = `WORD_ZERO;
    end else if (wr_now & is_mark & (req_sub_q == `SUB_MARK_DATE)) begin
      mark_date_d = req_data_q;
    end else if (wr_now & is_mark & (req_sub_q == `SUB_MARK_TIME)) begin
      mark_time_d = req_data_q;
    end
    ack_d = req_vld_q;
    err_d = 1'b0;
    rdata_d = `WORD_ZERO;
    if (req_vld_q & req_wr_q) begin
      if (is_store) err_d = ~store_ok;
      else if (is_disc) err_d = ~disc_ok;
      else if (is_mark) err_d = (req_sub_q != `SUB_MARK_DATE) && (req_sub_q != `SUB_MARK_TIME);
      else if (is_user) err_d = ~(user_go | mem_wr);
    end else if (req_vld_q) begin
      if (is_store | is_disc) begin
        if (req_sub_q == `SUB_ZERO) rdata_d = `CMD_HIGHEST_SUB;
        else if (is_store & (st_q == ST_SAVE) & (req_sub_q == cmd_sub_q)) rdata_d = `KEY_SAVE;
        else rdata_d = `WORD_ONE;
      end else if (is_mark) begin
        if (req_sub_q == `SUB_ZERO) rdata_d = `MARK_HIGHEST_SUB;
        else if (req_sub_q == `SUB_MARK_DATE) rdata_d = mark_date_q;
        else rdata_d = mark_time_q;
      end else if (is_user) begin
        if (req_sub_q == `SUB_ZERO) rdata_d = `USER_HIGHEST_SUB;
        else if (req_sub_q == `SUB_USER_START) rdata_d = {31'h0, user_flag_q};
        else rdata_d = {{(32 - USER_WIDTH){1'b0}}, mem_rdata};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mark_date_q <= `WORD_ZERO;
      mark_time_q <= `WORD_ZERO;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= `WORD_ZERO;
    end else begin
      mark_date_q <= mark_date_d;
      mark_time_q <= mark_time_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // Read address comes from the live request so data is ready one cycle on.
  user_value_mem #(.WIDTH(USER_WIDTH), .DEPTH(USER_DEPTH), .AW(3)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_wr),
    .wr_addr(3'(req_sub_q - `SUB_USER_FIRST)),
    .wr_data(req_data_q[USER_WIDTH-1:0]),
    .rd_addr(3'(od_sub - `SUB_USER_FIRST)),
    .rd_data(mem_rdata)
  );

  assign od_ack = ack_q;
  assign od_err = err_q;
  assign od_rdata = rdata_q;
  assign nv_req = nv_req_q;
  assign nv_op = nv_op_q;
  assign nv_mask = nv_mask_q;
  assign restart = restart_q;

  // Busy is taken from the next state so that it falls together with the return to idle.
  logic busy_q, busy_d;
  assign busy_d = (st_d != ST_IDLE);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy_q <= 1'b1;
    else busy_q <= busy_d;
  end
  assign busy = busy_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_save_start;
    @(posedge sys_clk) disable iff (rst) store_ok |=> nv_req && nv_op == NV_SAVE;
  endproperty
  a_save_start: assert property (p_save_start) else $error("save not started");

  property p_save_done;
    @(posedge sys_clk) disable iff (rst)
      req_vld_q && !req_wr_q && is_store && req_sub_q != `SUB_ZERO && idle
      |=> od_rdata == `WORD_ONE;
  endproperty
  a_save_done: assert property (p_save_done) else $error("save end not shown");

  property p_save_all_mask;
    @(posedge sys_clk) disable iff (rst)
      store_ok && req_sub_q == `SUB_ALL |=> nv_mask == `CAT_SAVE_ALL;
  endproperty
  a_save_all_mask: assert property (p_save_all_mask) else $error("save-all mask wrong");

  property p_discard_start;
    @(posedge sys_clk) disable iff (rst) disc_ok |=> nv_req && nv_op == NV_ERASE;
  endproperty
  a_discard_start: assert property (p_discard_start) else $error("discard missing");

  property p_keep_tuning;
    @(posedge sys_clk) disable iff (rst)
      nv_req && nv_op == NV_ERASE && nv_mask[`CAT_TUNING_BIT] |-> cmd_sub_q == `SUB_TUNING;
  endproperty
  a_keep_tuning: assert property (p_keep_tuning) else $error("tuning erased");

  property p_restart;
    @(posedge sys_clk) disable iff (rst)
      st_q == ST_ERASE && nv_done |=> restart ##2 (nv_req && nv_op == NV_LOAD);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart and reload");

  property p_marker_clear;
    @(posedge sys_clk) disable iff (rst) mark_clr |=> mark_date_q == 0 && mark_time_q == 0;
  endproperty
  a_marker_clear: assert property (p_marker_clear) else $error("marker kept");

  property p_reject;
    @(posedge sys_clk) disable iff (rst)
      wr_now && (is_store || is_disc) && !store_ok && !disc_ok |=> od_err && !nv_req;
  endproperty
  a_reject: assert property (p_reject) else $error("bad key accepted");

  property p_user_done;
    @(posedge sys_clk) disable iff (rst)
      st_q == ST_USER && nv_done |=> !user_flag_q && st_q == ST_IDLE;
  endproperty
  a_user_done: assert property (p_user_done) else $error("user flag stuck");

  c_save_all: cover property (@(posedge sys_clk) disable iff (rst)
    store_ok && req_sub_q == `SUB_ALL ##[1:100] st_q == ST_IDLE);
  c_discard_restart: cover property (@(posedge sys_clk) disable iff (rst) restart);
  c_user_save: cover property (@(posedge sys_clk) disable iff (rst) user_go ##[1:100] !user_flag_q);

endmodule

`default_nettype wire

// *** test/nv_store_model.sv ***
// Behavioural nonvolatile store that answers each operation after a settable delay.
`timescale 1ns/1ps
`default_nettype none

module nv_store_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic nv_req,
  input wire logic [7:0] delay,
  output var logic nv_done
);
  logic [7:0] cnt_q;
  logic run_q;

  // Each request restarts the count; a slow store is what makes the master poll.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      nv_done <= 1'b0;
    end else begin
      nv_done <= 1'b0;
      if (nv_req) begin
        run_q <= 1'b1;
        cnt_q <= delay;
      end else if (run_q && cnt_q == 8'h00) begin
        nv_done <= 1'b1;
        run_q <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** test/parameter_save_restore_bench.sv ***
// Self-checking bench for the save/restore block, driven through dictionary accesses.
`timescale 1ns/1ps
`default_nettype none
`include "save_restore_defines.svh"

module parameter_save_restore_bench;
  import save_restore_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic sys_clk, rst, od_wr, od_rd, od_savable, nv_done, od_ack, od_err, nv_req;
  logic restart, busy, got_err;
  logic [15:0] od_index;
  logic [7:0] od_sub, delay;
  logic [31:0] od_wdata, od_rdata, got;
  logic [5:0] nv_mask, last_mask;
  nv_op_type nv_op, last_op;
  int num_errors, comparisons, reqs, restarts, cycles, i, r0;
  logic [5:0] save_masks [6] = '{6'h3F, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
  logic [5:0] disc_masks [6] = '{6'h2F, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};

  parameter_save_restore u_dut (.sys_clk(sys_clk), .rst(rst), .od_wr(od_wr), .od_rd(od_rd),
    .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_savable(od_savable),
    .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata), .nv_req(nv_req), .nv_op(nv_op),
    .nv_mask(nv_mask), .nv_done(nv_done), .restart(restart), .busy(busy));

  nv_store_model u_store (.sys_clk(sys_clk), .rst(rst), .nv_req(nv_req), .delay(delay),
    .nv_done(nv_done));

  // The clock runs at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Store requests and restarts are logged, and a hang is cut short.
  always @(posedge sys_clk) begin
    cycles++;
    if (nv_req === 1'b1) begin
      reqs++;
      last_op = nv_op;
      last_mask = nv_mask;
    end
    if (restart === 1'b1) restarts++;
    if (cycles == 20000) begin
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  // One access; an extra cycle after the answer keeps the spacing and lets the log settle.
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] data, input logic sav);
    int n;
    @(posedge sys_clk);
    od_wr <= wr;
    od_rd <= ~wr;
    od_index <= idx;
    od_sub <= sub;
    od_wdata <= data;
    od_savable <= sav;
    @(posedge sys_clk);
    od_wr <= 1'b0;
    od_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (od_ack !== 1'b1 && n < 5);
    chk32({31'h0, od_ack}, 32'h1, "answer");
    got = od_rdata;
    got_err = od_err;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk32({31'h0, busy}, 32'h0, "idle");
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 32'h00000000;
    od_savable = 1'b0;
    delay = 8'h28;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    access(1'b1, `IDX_STORE_COMMAND, `SUB_ALL, `KEY_SAVE, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "busy boot");
    wait_idle();
    chk32({26'h0, last_mask}, 32'h3F, "boot mask");
    chk32({30'h0, last_op}, {30'h0, NV_LOAD}, "boot op");
    $display("test boot done");
    // Every store subindex, with the pending value read back before completion.
    for (i = 0; i < 6; i++) begin
      access(1'b1, `IDX_STORE_COMMAND, 8'(i + 1), `KEY_SAVE, 1'b0);
      chk32({31'h0, got_err}, 32'h0, "save err");
      chk32({26'h0, last_mask}, {26'h0, save_masks[i]}, "mask");
      chk32({30'h0, last_op}, {30'h0, NV_SAVE}, "save op");
      access(1'b0, `IDX_STORE_COMMAND, 8'(i + 1), 32'h0, 1'b0);
      chk32(got, `KEY_SAVE, "pending");
      wait_idle();
      access(1'b0, `IDX_STORE_COMMAND, 8'(i + 1), 32'h0, 1'b0);
      chk32(got, `WORD_ONE, "complete");
    end
    $display("test save done");
    r0 = reqs;
    access(1'b1, `IDX_STORE_COMMAND, `SUB_COMM, `KEY_DISCARD, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "bad key");
    access(1'b1, `IDX_STORE_COMMAND, 8'h07, `KEY_SAVE, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "bad sub");
    access(1'b1, `IDX_DISCARD_COMMAND, `SUB_ALL, `KEY_SAVE, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "bad discard key");
    chk32(32'(reqs), 32'(r0), "no store op");
    access(1'b0, 16'h6041, 8'h00, 32'h0, 1'b0);
    chk32(got, 32'h0, "unknown index");
    $display("test refuse done");
    // The marker is cleared by savable writes but survives save-all.
    access(1'b1, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h00012345, 1'b0);
    access(1'b1, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_TIME, 32'h00006789, 1'b0);
    access(1'b0, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_TIME, 32'h0, 1'b0);
    chk32(got, 32'h00006789, "time");
    access(1'b1, 16'h2030, 8'h00, 32'h5, 1'b1);
    access(1'b0, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h0, 1'b0);
    chk32(got, 32'h0, "date cleared");
    access(1'b1, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h00012345, 1'b0);
    access(1'b1, `IDX_STORE_COMMAND, `SUB_ALL, `KEY_SAVE, 1'b0);
    wait_idle();
    access(1'b0, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h0, 1'b0);
    chk32(got, 32'h00012345, "date kept");
    access(1'b1, `IDX_STORE_COMMAND, `SUB_COMM, `KEY_SAVE, 1'b0);
    wait_idle();
    access(1'b0, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h0, 1'b0);
    chk32(got, 32'h0, "date cleared by store");
    $display("test marker done");
    // User values keep only their low 16 bits.
    for (i = 0; i < 8; i++) begin
      access(1'b1, `IDX_USER_MEMORY_AREA, 8'(i + 2), 32'hFFFF0000 | (32'(i) * 32'h2357), 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      access(1'b0, `IDX_USER_MEMORY_AREA, 8'(i + 2), 32'h0, 1'b0);
      chk32(got, 32'(i) * 32'h2357, "user value");
    end
    access(1'b1, `IDX_USER_MEMORY_AREA, `SUB_USER_START, 32'h2, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "user start 2");
    access(1'b1, `IDX_USER_MEMORY_AREA, 8'h0A, 32'h1, 1'b0);
    chk32({31'h0, got_err}, 32'h1, "user sub 0A");
    access(1'b1, `IDX_USER_MEMORY_AREA, `SUB_USER_START, 32'h1, 1'b0);
    chk32({30'h0, last_op}, {30'h0, NV_USER}, "user op");
    access(1'b0, `IDX_USER_MEMORY_AREA, `SUB_USER_START, 32'h0, 1'b0);
    chk32(got, 32'h1, "user running");
    wait_idle();
    access(1'b0, `IDX_USER_MEMORY_AREA, `SUB_USER_START, 32'h0, 1'b0);
    chk32(got, 32'h0, "user done");
    $display("test user done");
    // Every discard subindex against a prompt store, each followed by a reboot.
    delay <= 8'h00;
    for (i = 0; i < 6; i++) begin
      r0 = restarts;
      access(1'b1, `IDX_DISCARD_COMMAND, 8'(i + 1), `KEY_DISCARD, 1'b0);
      chk32({31'h0, got_err}, 32'h0, "discard err");
      chk32({26'h0, last_mask}, {26'h0, disc_masks[i]}, "erase mask");
      chk32({30'h0, last_op}, {30'h0, NV_ERASE}, "erase op");
      wait_idle();
      chk32(32'(restarts), 32'(r0 + 1), "restart");
      chk32({30'h0, last_op}, {30'h0, NV_LOAD}, "reload op");
    end
    // The store-command write of subindex 02 cleared the marker, so it reads zero after restart.
    access(1'b0, `IDX_CONFIG_VERIFY_MARKER, `SUB_MARK_DATE, 32'h0, 1'b0);
    chk32(got, 32'h0, "marker after restart");
    $display("test discard done");
    wrap_up();
  end
endmodule

`default_nettype wire
